/* File: opas_consts.vh */
`ifndef OPAS_CONSTS_VH
`define OPAS_CONSTS_VH
// access types
`define OPAS_ACC_ADDR   3'h0
`define OPAS_ACC_BRANCH 3'h1
`define OPAS_ACC_MODIFY 3'h2
`define OPAS_ACC_READ   3'h3
`define OPAS_ACC_VAR    3'h4
`define OPAS_ACC_WRITE  3'h5
// data types
`define OPAS_DT_BYTE    3'h0
`define OPAS_DT_WORD    3'h1
`define OPAS_DT_LONG    3'h2
`define OPAS_DT_QUAD    3'h3
`define OPAS_DT_FLOAT   3'h4
`define OPAS_DT_DFLOAT  3'h5
`define OPAS_DT_FIRST   3'h6
`define OPAS_DT_SECOND  3'h7
// addressing modes
`define OPAS_AM_REG     3'h0
`define OPAS_AM_REGDEF  3'h1
`define OPAS_AM_AUTOINC 3'h2
`define OPAS_AM_AUTODEC 3'h3
`define OPAS_AM_AIDEF   3'h4
`define OPAS_AM_DISP    3'h5
// register aliases
`define OPAS_REG_PC     4'hf
`define OPAS_REG_SP     4'he
`define OPAS_REG_FP     4'hd
`define OPAS_REG_AP     4'hc
// commands
`define OPAS_CMD_SPEC   2'h0
`define OPAS_CMD_INDEX  2'h1
`define OPAS_CMD_XLATE  2'h2
`define OPAS_CMD_ADD    2'h3
// translation escape code
`define OPAS_XL_ESC     8'h1b
// states
`define OPAS_ST_IDLE    3'h0
`define OPAS_ST_MEMRD   3'h1
`define OPAS_ST_DEFRD   3'h2
`define OPAS_ST_MEMWR   3'h3
`define OPAS_ST_XLRD    3'h4
`define OPAS_ST_XLTBL   3'h5
`define OPAS_ST_XLWR    3'h6
`define OPAS_ST_DONE    3'h7
`endif

/* File: opas_unit.v */
`timescale 1ns/1ps
`default_nettype none
`include "opas_consts.vh"

// Summary of operation
// RULE1: an address-type operand returns its effective address as a 32-bit longword.
// RULE2: a branch-type operand makes no memory access and returns the displacement sized by data type.
// RULE3: a memory modify operand is checked for read and write access, read, then written back only if changed; a register one is always written.
// RULE4: a read operand is only fetched and a write operand is only stored.
// RULE5: a variable operand returns a memory address, or names register n or the pair n+1:n.
// RULE6: eight data types are decoded: byte, word, long, quad, float, double, first and second.
// RULE7: registers 15, 14, 13 and 12 are program counter, stack, frame and argument pointers.
// RULE8: only the destination, auto-mode register updates and pc advance are written.
// RULE9: operands are evaluated one specifier at a time in issue order.
// RULE10: condition codes follow the stored, truncated result; the add takes v from bit 31 of the full sum.
// RULE11: autoincrement uses then bumps the register; autodecrement drops it first.
// RULE12: the add takes its meaning from data type; float types are flagged to a float unit.
// RULE13: index checks the subscript against limits, scales and offsets, or raises a range trap.
// RULE14: translation looks up each byte, stopping at end of input, output, or escape with overflow.
// RULE15: after translation carry is set when output outlasted input, else clear.
// RULE16: absolute mode is autoincrement deferred through the program counter.
// RULE17: abort stops mid-operation and leaves state as it is.
module opas_unit (
  input  wire        clk_sys,    // clock
  input  wire        srst,       // sync reset
  input  wire        req,        // start pulse
  input  wire [1:0]  cmd,        // command
  input  wire [2:0]  acc,        // access type
  input  wire [2:0]  dtype,      // data type
  input  wire [2:0]  dt_first,   // instruction first type
  input  wire [2:0]  dt_second,  // instruction second type
  input  wire [2:0]  amode,      // addressing mode
  input  wire [3:0]  rnum,       // register number
  input  wire [31:0] disp,       // displacement
  input  wire [31:0] wdata,      // data to write / operand a
  input  wire [31:0] opb,        // operand b / lower limit
  input  wire [31:0] opc,        // upper limit / table base
  input  wire [31:0] opd,        // element size / src addr
  input  wire [31:0] ope,        // offset / dst addr
  input  wire [15:0] len_in,     // translate input length
  input  wire [15:0] len_out,    // translate output length
  input  wire        abort,      // abort now
  input  wire [31:0] rf_rdata,   // register file read data
  output reg  [3:0]  rf_raddr,   // register file read addr
  output reg         rf_we,      // register write
  output reg  [3:0]  rf_waddr,   // register write addr
  output reg  [31:0] rf_wdata,   // register write data
  output reg         mem_rd,     // memory read
  output reg         mem_wr,     // memory write
  output reg         mem_chk,    // access check read+write
  output reg  [31:0] mem_addr,   // memory address
  output reg  [31:0] mem_wdata,  // memory write data
  output reg  [2:0]  mem_size,   // resolved data type
  input  wire        mem_ack,    // memory done
  input  wire [31:0] mem_rdata,  // memory read data
  output reg         done,       // completion pulse
  output reg  [31:0] result,     // operand or result
  output reg         is_reg,     // operand lives in register
  output reg         is_pair,    // register pair n+1:n
  output reg         is_float,   // float semantics needed
  output reg  [3:0]  ccode,      // n z v c
  output reg         trap_range  // subscript range trap
);
  reg [2:0]  st_r;
  reg [31:0] addr_r, data_r, src_r, dst_r;
  reg [15:0] lin_r, lout_r;
  reg        mod_r;
  reg [2:0]  dt_r;
  reg [3:0]  rsel_r;
  reg [2:0]  am_r;

  // resolve instruction-defined types
  wire [2:0] dt_eff = (dtype == `OPAS_DT_FIRST) ? dt_first :          // RULE6
                      (dtype == `OPAS_DT_SECOND) ? dt_second : dtype; // RULE6
  reg [31:0] osize;
  always @* begin
    case (dt_eff)
      `OPAS_DT_BYTE:   osize = 32'h1;
      `OPAS_DT_WORD:   osize = 32'h2;
      `OPAS_DT_QUAD,
      `OPAS_DT_DFLOAT: osize = 32'h8;
      default:         osize = 32'h4;
    endcase
  end
  wire dt_fl = (dt_eff == `OPAS_DT_FLOAT) || (dt_eff == `OPAS_DT_DFLOAT);

  // stored-result flags, sized by type
  function [3:0] nz_of;
    input [31:0] v;
    input [2:0]  t;
    begin
      case (t)
        `OPAS_DT_BYTE: nz_of = {v[7], v[7:0] == 8'h00, 2'b00};
        `OPAS_DT_WORD: nz_of = {v[15], v[15:0] == 16'h0000, 2'b00};
        default:       nz_of = {v[31], v == 32'h0, 2'b00};
      endcase
    end
  endfunction

  wire [31:0] sum   = wdata + opb;
  wire [31:0] dec_a = rf_rdata - osize;
  wire [31:0] ea    = (amode == `OPAS_AM_DISP) ? rf_rdata + disp : rf_rdata;
  wire signed [31:0] sub_s = wdata;
  wire [31:0] idx   = wdata * opd + ope;

  always @(posedge clk_sys) begin
    rf_we  <= 1'b0;
    mem_rd <= 1'b0;
    mem_wr <= 1'b0;
    mem_chk <= 1'b0;
    done   <= 1'b0;
    if (srst) begin
      st_r <= `OPAS_ST_IDLE;
      rf_raddr <= 4'h0;
      rf_waddr <= 4'h0;
      rf_wdata <= 32'h0;
      mem_addr <= 32'h0;
      mem_wdata <= 32'h0;
      mem_size <= 3'h0;
      result <= 32'h0;
      is_reg <= 1'b0;
      is_pair <= 1'b0;
      is_float <= 1'b0;
      ccode <= 4'h0;
      trap_range <= 1'b0;
      addr_r <= 32'h0;
      data_r <= 32'h0;
      src_r <= 32'h0;
      dst_r <= 32'h0;
      lin_r <= 16'h0;
      lout_r <= 16'h0;
      mod_r <= 1'b0;
      dt_r <= 3'h0;
      rsel_r <= 4'h0;
      am_r <= 3'h0;
    end else if (abort && st_r != `OPAS_ST_IDLE) begin
      st_r <= `OPAS_ST_IDLE; // RULE17
      done <= 1'b1;
    end else begin
      case (st_r)
        `OPAS_ST_IDLE: begin
          rf_raddr <= rnum;
          if (req) begin
            trap_range <= 1'b0;
            is_reg <= 1'b0;
            is_pair <= 1'b0;
            is_float <= dt_fl; // RULE12
            dt_r <= dt_eff;
            mem_size <= dt_eff;
            case (cmd)
              `OPAS_CMD_INDEX: begin
                done <= 1'b1;
                if (sub_s < $signed(opb) || sub_s > $signed(opc))
                  trap_range <= 1'b1; // RULE13
                else
                  result <= idx; // RULE13
              end
              `OPAS_CMD_ADD: begin
                done <= 1'b1;
                result <= sum;
                // n and z from the truncated stored sum; v from bit 31 of the full sum
                ccode <= nz_of(sum, dt_eff) |
                  {2'b00, (wdata[31] == opb[31]) && (sum[31] != wdata[31]), 1'b0}; // RULE10 RULE12
              end
              `OPAS_CMD_XLATE: begin
                src_r <= opd; dst_r <= ope; addr_r <= opc;
                lin_r <= len_in; lout_r <= len_out;
                ccode <= 4'h0;
                st_r <= `OPAS_ST_XLRD;
              end
              default: begin
                // one specifier per request keeps evaluation in issue order
                am_r <= amode; // RULE9
                rsel_r <= rnum;
                if (acc == `OPAS_ACC_BRANCH) begin
                  done <= 1'b1; // RULE2
                  result <= (dt_eff == `OPAS_DT_BYTE) ? {{24{disp[7]}}, disp[7:0]} :
                            {{16{disp[15]}}, disp[15:0]}; // RULE2
                end else if (amode == `OPAS_AM_REG) begin
                  done <= 1'b1;
                  is_reg <= 1'b1; // RULE5
                  is_pair <= (osize == 32'h8); // RULE5
                  result <= rf_rdata;
                  if (acc == `OPAS_ACC_WRITE || acc == `OPAS_ACC_MODIFY) begin
                    rf_we <= 1'b1; rf_waddr <= rnum; rf_wdata <= wdata; // RULE8
                  end
                end else begin
                  // autodecrement adjusts before access
                  addr_r <= (amode == `OPAS_AM_AUTODEC) ? dec_a : ea; // RULE11
                  if (amode == `OPAS_AM_AUTODEC) begin
                    rf_we <= 1'b1; rf_waddr <= rnum; rf_wdata <= dec_a; // RULE11 RULE8
                  end else if (amode == `OPAS_AM_AUTOINC || amode == `OPAS_AM_AIDEF) begin
                    // deferred bumps by a longword; pc here is absolute mode
                    rf_we <= 1'b1; rf_waddr <= rnum; // RULE16 RULE7
                    rf_wdata <= rf_rdata + ((amode == `OPAS_AM_AIDEF) ? 32'h4 : osize); // RULE11
                  end
                  if (amode == `OPAS_AM_AIDEF) begin
                    mem_rd <= 1'b1; mem_addr <= rf_rdata; mem_size <= `OPAS_DT_LONG; // RULE16
                    st_r <= `OPAS_ST_DEFRD;
                  end else begin
                    st_r <= `OPAS_ST_MEMRD;
                  end
                  data_r <= {29'h0, acc};
                end
              end
            endcase
          end
        end
        `OPAS_ST_DEFRD: if (mem_ack) begin
          addr_r <= mem_rdata;
          mem_size <= dt_r;
          st_r <= `OPAS_ST_MEMRD;
        end
        `OPAS_ST_MEMRD: begin
          // address in hand: act by access type
          case (data_r[2:0])
            `OPAS_ACC_ADDR, `OPAS_ACC_VAR: begin
              result <= addr_r; done <= 1'b1; st_r <= `OPAS_ST_IDLE; // RULE1 RULE5
            end
            `OPAS_ACC_WRITE: begin
              mem_wr <= 1'b1; mem_addr <= addr_r; mem_wdata <= wdata; // RULE4
              st_r <= `OPAS_ST_MEMWR;
            end
            default: begin
              mem_rd <= 1'b1; mem_addr <= addr_r; // RULE4
              mem_chk <= (data_r[2:0] == `OPAS_ACC_MODIFY); // RULE3
              st_r <= `OPAS_ST_DONE;
            end
          endcase
        end
        `OPAS_ST_DONE: if (mem_ack) begin
          result <= mem_rdata;
          if (data_r[2:0] == `OPAS_ACC_MODIFY && mem_rdata != wdata) begin
            mem_wr <= 1'b1; mem_wdata <= wdata; // RULE3
            st_r <= `OPAS_ST_MEMWR;
          end else begin
            done <= 1'b1; st_r <= `OPAS_ST_IDLE; // RULE3
          end
        end
        `OPAS_ST_MEMWR: if (mem_ack) begin
          done <= 1'b1; st_r <= `OPAS_ST_IDLE;
        end
        `OPAS_ST_XLRD: begin
          if (lin_r == 16'h0 || lout_r == 16'h0) begin
            ccode[0] <= (lin_r == 16'h0) && (lout_r != 16'h0); // RULE15
            done <= 1'b1; // RULE14
            st_r <= `OPAS_ST_IDLE;
          end else begin
            mem_rd <= 1'b1; // RULE14
            mem_addr <= src_r;
            mem_size <= `OPAS_DT_BYTE;
            st_r <= `OPAS_ST_XLTBL;
          end
        end
        `OPAS_ST_XLTBL: if (mem_ack) begin
          mem_rd <= 1'b1;
          mem_addr <= addr_r + {24'h0, mem_rdata[7:0]}; // RULE14
          st_r <= `OPAS_ST_XLWR;
        end
        `OPAS_ST_XLWR: if (mem_ack) begin
          if (mem_rdata[7:0] == `OPAS_XL_ESC) begin
            ccode[1] <= 1'b1; // RULE14
            done <= 1'b1;
            st_r <= `OPAS_ST_IDLE;
          end else begin
            // write ack is not awaited; next step reads straight away
            mem_wr <= 1'b1; // RULE14
            mem_addr <= dst_r;
            mem_wdata <= {24'h0, mem_rdata[7:0]};
            src_r <= src_r + 32'h1;
            dst_r <= dst_r + 32'h1;
            lin_r <= lin_r - 16'h1;
            lout_r <= lout_r - 16'h1;
            st_r <= `OPAS_ST_XLRD;
          end
        end
        default: st_r <= `OPAS_ST_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

/* File: opas_unit_properties.sv */
`timescale 1ns/1ps
`default_nettype none
`include "opas_consts.vh"
module opas_unit_properties (
  input wire logic        clk_sys,   // clock
  input wire logic        srst,      // reset
  input wire logic        req,       // start
  input wire logic [1:0]  cmd,       // command
  input wire logic [2:0]  acc,       // access
  input wire logic [2:0]  dtype,     // type
  input wire logic [2:0]  amode,     // mode
  input wire logic [31:0] wdata,     // a
  input wire logic [31:0] opb,       // b
  input wire logic [31:0] opc,       // c
  input wire logic [31:0] opd,       // d
  input wire logic [31:0] ope,       // e
  input wire logic [31:0] rf_rdata,  // reg value
  input wire logic        rf_we,     // reg write
  input wire logic [31:0] rf_wdata,  // reg data
  input wire logic        mem_rd,    // read
  input wire logic        mem_wr,    // write
  input wire logic [31:0] mem_addr,  // address
  input wire logic        done,      // done
  input wire logic [31:0] result,    // result
  input wire logic [3:0]  ccode,     // nzvc
  input wire logic        trap_range // trap
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  logic        busy_r;
  logic [1:0]  cmd_r;
  logic [2:0]  acc_r, dt_r;
  logic [31:0] a_r, b_r, c_r, d_r, e_r;
  wire         start = req && !busy_r;
  wire         rdl = start && cmd == `OPAS_CMD_SPEC && acc == `OPAS_ACC_READ && dtype == `OPAS_DT_LONG;
  wire         in_rng = $signed(a_r) >= $signed(b_r) && $signed(a_r) <= $signed(c_r);
  wire  [31:0] sum = a_r + b_r;
  // busy shadow lets operand-kind checks span the whole operation
  always @(posedge clk_sys) begin
    busy_r <= srst ? 1'b0 : (start ? 1'b1 : (done ? 1'b0 : busy_r));
    if (start) begin
      {cmd_r, acc_r, dt_r} <= {cmd, acc, dtype};
      {a_r, b_r, c_r, d_r, e_r} <= {wdata, opb, opc, opd, ope};
    end
  end
  a_done_pulse: assert property (done |=> !done) else $error("done wider than one cycle");
  a_branch_quiet: assert property (start && cmd == `OPAS_CMD_SPEC && acc == `OPAS_ACC_BRANCH |=>
    done && !mem_rd && !mem_wr) else $error("branch operand touched memory");
  a_read_no_store: assert property (busy_r && cmd_r == `OPAS_CMD_SPEC && acc_r == `OPAS_ACC_READ |->
    !mem_wr) else $error("read operand stored");
  a_write_no_fetch: assert property (busy_r && cmd_r == `OPAS_CMD_SPEC && acc_r == `OPAS_ACC_WRITE |->
    !mem_rd) else $error("write operand fetched");
  a_index_turn: assert property (start && cmd == `OPAS_CMD_INDEX |=> done) else $error("index late");
  a_index_value: assert property (done && cmd_r == `OPAS_CMD_INDEX |-> trap_range == !in_rng &&
    (!in_rng || result == a_r * d_r + e_r)) else $error("index result or trap wrong");
  a_add_flags: assert property (done && cmd_r == `OPAS_CMD_ADD && dt_r == `OPAS_DT_LONG |->
    result == sum && ccode[3:1] == {sum[31], sum == 32'h0, a_r[31] == b_r[31] && sum[31] != a_r[31]})
    else $error("add result or flags wrong");
  a_autoinc_step: assert property (rdl && amode == `OPAS_AM_AUTOINC |=>
    rf_we && rf_wdata == $past(rf_rdata) + 32'h4 ##1 mem_rd && mem_addr == $past(rf_rdata, 2))
    else $error("autoincrement order wrong");
  a_autodec_step: assert property (rdl && amode == `OPAS_AM_AUTODEC |=>
    rf_we && rf_wdata == $past(rf_rdata) - 32'h4 ##1 mem_rd && mem_addr == $past(rf_rdata, 2) - 32'h4)
    else $error("autodecrement order wrong");
endmodule
bind opas_unit opas_unit_properties i_props (.clk_sys, .srst, .req, .cmd, .acc, .dtype, .amode, .wdata, .opb,
  .opc, .opd, .ope, .rf_rdata, .rf_we, .rf_wdata, .mem_rd, .mem_wr, .mem_addr, .done, .result, .ccode, .trap_range);
`default_nettype wire

/* File: opas_mem_model.sv */
`timescale 1ns/1ps
`default_nettype none
module opas_mem_model (
  input  wire logic        clk_sys,   // clock
  input  wire logic        slow,      // long answer delay
  input  wire logic        ack_wr,    // answer writes too
  input  wire logic [3:0]  rf_raddr,  // reg read addr
  input  wire logic        rf_we,     // reg write
  input  wire logic [3:0]  rf_waddr,  // reg write addr
  input  wire logic [31:0] rf_wdata,  // reg write data
  output logic      [31:0] rf_rdata,  // reg read data
  input  wire logic        mem_rd,    // read
  input  wire logic        mem_wr,    // write
  input  wire logic [31:0] mem_addr,  // address
  input  wire logic [31:0] mem_wdata, // write data
  output logic             mem_ack = 1'b0, // answer
  output logic      [31:0] mem_rdata = 32'h0 // read data
);
  logic [31:0] rf [0:15];
  logic [31:0] mem [0:1023];
  logic        pend_r = 1'b0;
  logic [1:0]  wait_r = 2'h0;
  logic [9:0]  a_r = 10'h0;
  assign rf_rdata = rf[rf_raddr];
  always @(posedge clk_sys) begin
    mem_ack <= 1'b0;
    mem_rdata <= ~mem_rdata; // data is only valid with the answer
    if (rf_we) rf[rf_waddr] <= rf_wdata;
    if (mem_wr) mem[mem_addr[9:0]] <= mem_wdata;
    if (pend_r && wait_r == 2'h0) begin
      mem_ack <= 1'b1;
      mem_rdata <= mem[a_r];
      pend_r <= 1'b0;
    end else if (pend_r) wait_r <= wait_r - 2'h1;
    if (mem_rd || (mem_wr && ack_wr)) begin
      pend_r <= 1'b1;
      wait_r <= slow ? 2'h3 : 2'h0;
      a_r <= mem_addr[9:0];
    end
  end
endmodule
`default_nettype wire

/* File: opas_unit_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module opas_unit_tb;
  typedef struct packed {logic [1:0] c; logic [2:0] ac, dt, am; logic [3:0] rn, cc, ccm;
    logic [31:0] a, b, h, d, e, res; logic tr, pr;} opas_row_t;
  logic        clk_sys = 1'b0, srst = 1'b1, req = 1'b0, abort = 1'b0, slow = 1'b0, ack_wr = 1'b1;
  logic [1:0]  cmd = 2'h0;
  logic [2:0]  acc = 3'h0, dtype = 3'h2, amode = 3'h0;
  logic [3:0]  rnum = 4'h0;
  logic [2:0]  dt_first = 3'h4, dt_second = 3'h5;
  wire  [2:0]  mem_size;
  wire         is_reg, is_float;
  logic [31:0] disp = 32'h0, wdata = 32'h0, opb = 32'h0, opc = 32'h0, opd = 32'h0, ope = 32'h0;
  logic [15:0] len_in = 16'h0, len_out = 16'h0;
  wire  [31:0] rf_rdata, rf_wdata, mem_addr, mem_wdata, mem_rdata, result;
  wire  [3:0]  rf_raddr, rf_waddr, ccode;
  wire         rf_we, mem_rd, mem_wr, mem_chk, mem_ack, done, is_pair, trap_range;
  logic        saw_chk = 1'b0, saw_rd = 1'b0;
  int          mismatches = 0, n_compared = 0;
  opas_row_t   rows [8];
  opas_unit i_opas_unit (.clk_sys, .srst, .req, .cmd, .acc, .dtype, .dt_first, .dt_second, .amode,
    .rnum, .disp, .wdata, .opb, .opc, .opd, .ope, .len_in, .len_out, .abort, .rf_rdata, .rf_raddr, .rf_we,
    .rf_waddr, .rf_wdata, .mem_rd, .mem_wr, .mem_chk, .mem_addr, .mem_wdata, .mem_size, .mem_ack, .mem_rdata,
    .done, .result, .is_reg, .is_pair, .is_float, .ccode, .trap_range);
  opas_mem_model i_opas_mem_model (.clk_sys, .slow, .ack_wr, .rf_raddr, .rf_we, .rf_waddr, .rf_wdata, .rf_rdata,
    .mem_rd, .mem_wr, .mem_addr, .mem_wdata, .mem_ack, .mem_rdata);
  initial forever #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    if (mem_chk) saw_chk <= 1'b1;
    if (mem_rd) saw_rd <= 1'b1;
  end
  task automatic tally_and_finish;
    if (mismatches == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    n_compared++;
    if (g !== e) begin
      $display("BAD %s expected %h seen %h", nm, e, g);
      mismatches++;
    end
  endtask
  task automatic go;
    int k;
    @(negedge clk_sys);
    req = 1'b1;
    @(negedge clk_sys);
    req = 1'b0;
    for (k = 0; k < 200 && done !== 1'b1; k++) @(negedge clk_sys);
    if (done !== 1'b1) begin
      mismatches++;
      tally_and_finish;
    end
  endtask
  task automatic setop(input logic [1:0] c, input logic [2:0] ac, am, input logic [3:0] rn);
    {cmd, acc, amode, rnum, saw_chk, saw_rd} = {c, ac, am, rn, 2'b00};
    go;
  endtask
  task automatic xl(input logic [15:0] li, lo, input logic [9:0] dst, at, input logic [3:0] cc, input logic [7:0] ex);
    {len_in, len_out, ope} = {li, lo, 22'h0, dst};
    setop(2'h2, 3'h0, 3'h0, 4'h0);
    chk("xl_vc", {28'h0, cc}, {28'h0, ccode & 4'h3});
    chk("xl_out", {24'h0, ex}, {24'h0, i_opas_mem_model.mem[at][7:0]});
  endtask
  initial begin
    // cmd acc dt am rn cc ccm a b hi size off res trap pair
    rows[0] = '{2'h1, 3'h0, 3'h2, 3'h0, 4'h0, 4'h0, 4'h0, 32'h3, 32'h1, 32'ha, 32'h5, 32'hfffffffb, 32'ha, 1'b0, 1'b0};
    rows[1] = '{2'h1, 3'h0, 3'h2, 3'h0, 4'h0, 4'h0, 4'h0, 32'ha, 32'h1, 32'ha, 32'h5, 32'hfffffffb, 32'h2d, 1'b0, 1'b0};
    rows[2] = '{2'h1, 3'h0, 3'h2, 3'h0, 4'h0, 4'h0, 4'h0, 32'hb, 32'h1, 32'ha, 32'h5, 32'hfffffffb, 32'h0, 1'b1, 1'b0};
    rows[3] = '{2'h3, 3'h0, 3'h2, 3'h0, 4'h0, 4'ha, 4'he, 32'h7fffffff, 32'h1, 32'h0, 32'h0, 32'h0, 32'h80000000, 1'b0, 1'b0};
    rows[4] = '{2'h3, 3'h0, 3'h2, 3'h0, 4'h0, 4'h4, 4'he, 32'h1, 32'hffffffff, 32'h0, 32'h0, 32'h0, 32'h0, 1'b0, 1'b0};
    rows[5] = '{2'h0, 3'h1, 3'h0, 3'h0, 4'h0, 4'h0, 4'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h5, 32'h5, 1'b0, 1'b0};
    rows[6] = '{2'h0, 3'h0, 3'h2, 3'h5, 4'h2, 4'h0, 4'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h8, 32'h108, 1'b0, 1'b0};
    rows[7] = '{2'h0, 3'h4, 3'h3, 3'h0, 4'h2, 4'h0, 4'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 1'b0, 1'b1};
    i_opas_mem_model.rf[2] = 32'h100;
    repeat (10) @(negedge clk_sys);
    srst = 1'b0;
    chk("rst_out", 32'h0, {result[31:6], done, trap_range, ccode}); // reset clears outputs
    foreach (rows[i]) begin
      {wdata, opb, opc, opd, ope, disp, dtype} = {rows[i].a, rows[i].b, rows[i].h, rows[i].d, rows[i].e, rows[i].e, rows[i].dt};
      setop(rows[i].c, rows[i].ac, rows[i].am, rows[i].rn);
      if (rows[i].c == 2'h1) chk("trap", {31'h0, rows[i].tr}, {31'h0, trap_range});
      if (!rows[i].tr && !rows[i].pr) chk("result", rows[i].res, result);
      chk("ccode", {28'h0, rows[i].cc}, {28'h0, ccode & rows[i].ccm});
      if (rows[i].c == 2'h0) chk("pair", {31'h0, rows[i].pr}, {31'h0, is_pair});
      if (rows[i].c == 2'h0) chk("is_reg", {31'h0, rows[i].am == 3'h0 && rows[i].ac != 3'h1}, {31'h0, is_reg});
    end
    {dtype, wdata, opb} = {3'h6, 32'h2, 32'h3};
    setop(2'h3, 3'h0, 3'h0, 4'h0);
    chk("first_float", 32'h14, {27'h0, is_float, 1'b0, mem_size});
    dtype = 3'h7;
    setop(2'h3, 3'h0, 3'h0, 4'h0);
    chk("second_dfloat", 32'h15, {27'h0, is_float, 1'b0, mem_size});
    dtype = 3'h2;
    {i_opas_mem_model.rf[4], i_opas_mem_model.mem[16]} = {32'h10, 32'habcd};
    setop(2'h0, 3'h3, 3'h2, 4'h4);
    chk("autoinc", 32'h14abcd, {i_opas_mem_model.rf[4][15:0], result[15:0]});
    slow = 1'b1;
    {i_opas_mem_model.rf[5], i_opas_mem_model.mem[28]} = {32'h20, 32'h1234};
    setop(2'h0, 3'h3, 3'h3, 4'h5);
    chk("autodec", 32'h1c1234, {i_opas_mem_model.rf[5][15:0], result[15:0]});
    {i_opas_mem_model.rf[15], i_opas_mem_model.mem[48], i_opas_mem_model.mem[64]} = {32'h30, 32'h40, 32'h77};
    setop(2'h0, 3'h3, 3'h4, 4'hf);
    chk("absolute", 32'h340077, {i_opas_mem_model.rf[15][15:0], result[15:0]});
    {i_opas_mem_model.rf[6], i_opas_mem_model.mem[80], wdata} = {32'h50, 32'h5, 32'h9};
    setop(2'h0, 3'h2, 3'h1, 4'h6);
    chk("modify", 32'h19, {saw_chk, i_opas_mem_model.mem[80][3:0]});
    {i_opas_mem_model.rf[7], wdata} = {32'h58, 32'h66};
    setop(2'h0, 3'h5, 3'h1, 4'h7);
    chk("wr_only", 32'h66, {saw_rd, i_opas_mem_model.mem[88][7:0]});
    {slow, ack_wr, opc, opd, i_opas_mem_model.mem[178]} = {2'b00, 32'h200, 32'h80, 32'hee};
    foreach (rows[i]) i_opas_mem_model.mem[128 + i] = {24'h0, 8'h1, 8'h43, 8'h61, 8'h1a, 8'h1b, 24'h0} >> (8 * (7 - i)) & 32'hff;
    {i_opas_mem_model.mem[513], i_opas_mem_model.mem[579], i_opas_mem_model.mem[609]} = {32'h1, 32'h43, 32'h41};
    {i_opas_mem_model.mem[538], i_opas_mem_model.mem[539]} = {32'h1a, 32'h1b};
    xl(16'h5, 16'h8, 10'h90, 10'h92, 4'h2, 8'h41);
    xl(16'h3, 16'h8, 10'ha0, 10'ha2, 4'h1, 8'h41);
    xl(16'h3, 16'h2, 10'hb0, 10'hb2, 4'h0, 8'hee);
    {slow, ack_wr} = 2'b11;
    setop(2'h0, 3'h2, 3'h1, 4'h6);
    chk("abort_idle", 32'h0, {31'h0, req}); // abort follows a finished op
    @(negedge clk_sys);
    req = 1'b1;
    @(negedge clk_sys);
    {req, abort} = 2'b01;
    repeat (8) if (done !== 1'b1) @(negedge clk_sys);
    chk("abort_done", 32'h1, {31'h0, done});
    abort = 1'b0;
    tally_and_finish;
  end
endmodule
`default_nettype wire
